// >>> shared/hpr_pkg.sv
// constants, layouts and types of the host read port
// assumes a single 200 MHz core clock and a 16-bit host data bus
package hpr_pkg;
   localparam int CLK_PERIOD_NS = 5;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 16;
   localparam int LANE_W = 2;
   localparam int HI_LSB = 2;
   localparam int BURST_MAX = 16;
   localparam int BCNT_W = 5;
   localparam int BUF_DEPTH = 2;
   // word offsets on host address lines 7..1
   localparam logic [4:0] RXD_HI = 5'h00;
   localparam logic [6:0] RXS_WORD = 7'h20;
   localparam logic [6:0] TXS_WORD = 7'h24;
   localparam logic [DATA_W-1:0] EMPTY_WORD = 16'h0000;
   localparam logic [BCNT_W-1:0] BCNT_ZERO = 5'h00;
   localparam logic [BCNT_W-1:0] BCNT_ONE = 5'h01;
   localparam logic [BCNT_W-1:0] BCNT_LIMIT = 5'h10;

   typedef enum logic [1:0] {
      TGT_CSR,
      TGT_RXD,
      TGT_RXS,
      TGT_TXS
   } hpr_target_t;

   typedef struct packed {
      hpr_target_t tgt;
      logic [LANE_W-1:0] lane;
   } hpr_access_t;

   typedef enum logic {
      ST_IDLE,
      ST_ACTIVE
   } hpr_state_t;
endpackage : hpr_pkg

// >>> hdl/hpr_read_port.sv
// host read port: strobe sync, decode, snapshot, fifo pops, rx buffer
// assumes pins asynchronous to clk_in; csr_rdata_in follows csr_addr_out
//
// Contract
// - Register data, counters included, is captured at the start of each read access.
// - An access runs while chip select and read strobe are both low and ends when either rises, in any order.
// - A register burst allows up to 16 word reads, one per address change, with strobes held low.
// - With fifo select high the upper address is ignored and the next rx data word is returned.
// - Fifo-direct bursts are unlimited in length while the strobes stay low.
// - Fifo-direct reads still use address bits 2 and 1 and ignore bits 7 to 3.
// - Register mode reaches the registers, the rx data fifo and both status fifos.
`timescale 1ns/1ps
`default_nettype none
module hpr_read_port #(
   parameter int DATA_W = hpr_pkg::DATA_W
) (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // host pins
   input wire logic chip_select_n_in,
   input wire logic read_strobe_n_in,
   input wire logic fifo_sel_in,
   input wire logic [hpr_pkg::ADDR_W-1:0] addr_in,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe_out,
   // rx data word source
   input wire logic [DATA_W-1:0] rx_word_in,
   input wire logic rx_valid_in,
   output logic rx_ready_out,
   // status fifo heads
   input wire logic [DATA_W-1:0] rxs_word_in,
   input wire logic [DATA_W-1:0] txs_word_in,
   output logic rxs_pop_out,
   output logic txs_pop_out,
   // register file
   output logic [hpr_pkg::ADDR_W-1:0] csr_addr_out,
   input wire logic [DATA_W-1:0] csr_rdata_in,
   output logic csr_snap_out,
   // status
   output logic [hpr_pkg::LANE_W-1:0] lane_out,
   output logic rx_underrun_out,
   output logic burst_over_out
);
   localparam int AW = hpr_pkg::ADDR_W;

   function automatic hpr_pkg::hpr_access_t decode(
      input logic fs,
      input logic [AW-1:0] a
   );
      hpr_pkg::hpr_access_t d;
      d.lane = a[hpr_pkg::LANE_W-1:0];
      if (fs) begin
         d.tgt = hpr_pkg::TGT_RXD;
      end else if (a[AW-1:hpr_pkg::HI_LSB] == hpr_pkg::RXD_HI) begin
         d.tgt = hpr_pkg::TGT_RXD;
      end else if (a == hpr_pkg::RXS_WORD) begin
         d.tgt = hpr_pkg::TGT_RXS;
      end else if (a == hpr_pkg::TXS_WORD) begin
         d.tgt = hpr_pkg::TGT_TXS;
      end else begin
         d.tgt = hpr_pkg::TGT_CSR;
      end
      return d;
   endfunction : decode

   // two-flop synchronisers; the host holds address and select like
   // address lines, so a third address stage confirms a settled value
   logic cs_s1_r, cs_s2_r, rd_s1_r, rd_s2_r, fs_s1_r, fs_s2_r;
   logic [AW-1:0] a_s1_r, a_s2_r, a_s3_r;
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         {cs_s1_r, cs_s2_r, rd_s1_r, rd_s2_r} <= 4'hF;
         {fs_s1_r, fs_s2_r} <= 2'h0;
         a_s1_r <= '0;
         a_s2_r <= '0;
         a_s3_r <= '0;
      end else begin
         {cs_s1_r, cs_s2_r} <= {chip_select_n_in, cs_s1_r};
         {rd_s1_r, rd_s2_r} <= {read_strobe_n_in, rd_s1_r};
         {fs_s1_r, fs_s2_r} <= {fifo_sel_in, fs_s1_r};
         a_s1_r <= addr_in;
         a_s2_r <= a_s1_r;
         a_s3_r <= a_s2_r;
      end
   end

   hpr_pkg::hpr_state_t state_r, state_nxt;
   hpr_pkg::hpr_access_t cur_r;
   logic [AW-1:0] cur_addr_r;
   logic got_r;
   logic [hpr_pkg::BCNT_W-1:0] bcnt_r;
   logic [DATA_W-1:0] data_r;

   // two-entry rx buffer
   logic [DATA_W-1:0] mem_r [hpr_pkg::BUF_DEPTH];
   logic wp_r, rp_r;
   logic [1:0] cnt_r;

   wire logic act = !cs_s2_r && !rd_s2_r;
   wire logic stable = (a_s2_r == a_s3_r);
   wire hpr_pkg::hpr_access_t acc = decode(fs_s2_r, a_s2_r);
   wire logic start = (state_r == hpr_pkg::ST_IDLE) && act && stable;
   // any address change inside a burst closes the current word
   wire logic fin = (state_r == hpr_pkg::ST_ACTIVE) &&
                    (!act || (stable && a_s2_r != cur_addr_r));
   wire logic buf_empty = (cnt_r == 2'h0);
   wire logic push = rx_valid_in && rx_ready_out;
   wire logic pop = fin && cur_r.tgt == hpr_pkg::TGT_RXD && got_r;
   wire logic [1:0] cnt_nxt = cnt_r + {1'b0, push} - {1'b0, pop};
   wire logic reg_mode = !fs_s2_r;
   wire logic over = start && reg_mode && bcnt_r == hpr_pkg::BCNT_LIMIT;
   // counters in the register file are frozen at the access start
   wire logic [DATA_W-1:0] sel_word =
      (acc.tgt == hpr_pkg::TGT_RXD) ?
         (buf_empty ? hpr_pkg::EMPTY_WORD : mem_r[rp_r]) :
      (acc.tgt == hpr_pkg::TGT_RXS) ? rxs_word_in :
      (acc.tgt == hpr_pkg::TGT_TXS) ? txs_word_in : csr_rdata_in;

   always_comb begin
      state_nxt = state_r;
      case (state_r)
         hpr_pkg::ST_IDLE: begin
            if (start) begin
               state_nxt = hpr_pkg::ST_ACTIVE;
            end
         end
         hpr_pkg::ST_ACTIVE: begin
            if (fin) begin
               state_nxt = hpr_pkg::ST_IDLE;
            end
         end
         default: state_nxt = hpr_pkg::ST_IDLE;
      endcase
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         state_r <= hpr_pkg::ST_IDLE;
         cur_r <= '0;
         cur_addr_r <= '0;
         got_r <= 1'b0;
         data_r <= '0;
      end else begin
         state_r <= state_nxt;
         if (start) begin
            cur_r <= acc;
            cur_addr_r <= a_s2_r;
            got_r <= !buf_empty;
            data_r <= sel_word;
         end
      end
   end

   // burst word count; fifo-direct starts never count toward the limit
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         bcnt_r <= hpr_pkg::BCNT_ZERO;
         burst_over_out <= 1'b0;
      end else if (!act) begin
         bcnt_r <= hpr_pkg::BCNT_ZERO;
         burst_over_out <= 1'b0;
      end else if (start && reg_mode) begin
         if (bcnt_r != hpr_pkg::BCNT_LIMIT) begin
            bcnt_r <= bcnt_r + hpr_pkg::BCNT_ONE;
         end
         burst_over_out <= burst_over_out || over;
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         data_oe_out <= 1'b0;
         rxs_pop_out <= 1'b0;
         txs_pop_out <= 1'b0;
         csr_snap_out <= 1'b0;
         lane_out <= '0;
         rx_underrun_out <= 1'b0;
      end else begin
         data_oe_out <= act;
         rxs_pop_out <= fin && cur_r.tgt == hpr_pkg::TGT_RXS;
         txs_pop_out <= fin && cur_r.tgt == hpr_pkg::TGT_TXS;
         csr_snap_out <= start;
         if (start) begin
            lane_out <= acc.lane;
            rx_underrun_out <= acc.tgt == hpr_pkg::TGT_RXD && buf_empty;
         end
      end
   end

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         wp_r <= 1'b0;
         rp_r <= 1'b0;
         cnt_r <= 2'h0;
         rx_ready_out <= 1'b0;
      end else begin
         if (push) begin
            wp_r <= !wp_r;
         end
         if (pop) begin
            rp_r <= !rp_r;
         end
         cnt_r <= cnt_nxt;
         rx_ready_out <= cnt_nxt != 2'h2;
      end
   end

   always_ff @(posedge clk_in) begin
      if (push) begin
         mem_r[wp_r] <= rx_word_in;
      end
   end

   assign data_out = data_r;
   assign csr_addr_out = a_s2_r;

   snap_on_start_a: assert property (@(posedge clk_in) disable iff (rst_in)
      start && acc.tgt == hpr_pkg::TGT_CSR |=>
         csr_snap_out && data_out == $past(csr_rdata_in))
      else $error("register data not captured at access start");
   oe_follows_strobes_a: assert property (@(posedge clk_in)
      disable iff (rst_in) ##1 data_oe_out == $past(act))
      else $error("data enable not tied to both strobes low");
   status_pop_once_a: assert property (@(posedge clk_in)
      disable iff (rst_in) rxs_pop_out |=> !rxs_pop_out)
      else $error("status fifo popped twice for one read");
   fifo_sel_route_a: assert property (@(posedge clk_in)
      disable iff (rst_in) start && fs_s2_r |=> cur_r.tgt == hpr_pkg::TGT_RXD)
      else $error("fifo select read not routed to rx data");
   lane_kept_a: assert property (@(posedge clk_in) disable iff (rst_in)
      start && fs_s2_r |=> lane_out == $past(a_s2_r[hpr_pkg::LANE_W-1:0]))
      else $error("low address bits lost in fifo direct read");
   burst_limit_a: assert property (@(posedge clk_in)
      disable iff (rst_in)
      start && reg_mode && bcnt_r == hpr_pkg::BCNT_LIMIT |=> burst_over_out)
      else $error("seventeenth register burst word not flagged");
   fifo_unlimited_a: assert property (@(posedge clk_in)
      disable iff (rst_in) start && fs_s2_r |=> !$rose(burst_over_out))
      else $error("fifo direct burst flagged as too long");
   status_route_a: assert property (@(posedge clk_in)
      disable iff (rst_in) start && reg_mode && a_s2_r == hpr_pkg::TXS_WORD
      |=> cur_r.tgt == hpr_pkg::TGT_TXS ##1 1'b1)
      else $error("tx status address not routed");
   buffer_drain_a: assert property (@(posedge clk_in)
      disable iff (rst_in) pop && !push |=> cnt_r == $past(cnt_r) - 2'h1)
      else $error("rx buffer count wrong after a completed read");
   buffer_word_a: assert property (@(posedge clk_in)
      disable iff (rst_in) start && acc.tgt == hpr_pkg::TGT_RXD && !buf_empty
      |=> data_out == $past(mem_r[rp_r]))
      else $error("rx data word not presented");
endmodule : hpr_read_port
`default_nettype wire

// >>> tb/hpr_far_model.sv
// far-side model: rx word source, status fifo heads, register file
// assumes the same clock as the read port
`timescale 1ns/1ps
`default_nettype none
module hpr_far_model (
   // clock and reset
   input wire logic clk_in,
   input wire logic rst_in,
   // rx word source
   input wire logic src_en_in,
   input wire logic rx_ready_in,
   output logic [15:0] rx_word_out,
   output logic rx_valid_out,
   // status heads and registers
   input wire logic rxs_pop_in,
   input wire logic txs_pop_in,
   input wire logic [6:0] csr_addr_in,
   output logic [15:0] rxs_word_out,
   output logic [15:0] txs_word_out,
   output logic [15:0] csr_rdata_out
);
   logic [15:0] rx_n_r;
   logic [15:0] rxs_n_r;
   logic [15:0] txs_n_r;
   assign rx_valid_out = src_en_in;
   // idle source shows the inverse, so a stale word never matches
   assign rx_word_out = src_en_in ? 16'hC000 + rx_n_r : ~(16'hC000 + rx_n_r);
   assign rxs_word_out = 16'h5000 + rxs_n_r;
   assign txs_word_out = 16'h6000 + txs_n_r;
   assign csr_rdata_out = {csr_addr_in, 9'h055};
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         rx_n_r <= 16'h0000;
         rxs_n_r <= 16'h0000;
         txs_n_r <= 16'h0000;
      end else begin
         rx_n_r <= rx_n_r + {15'h0000, rx_valid_out & rx_ready_in};
         rxs_n_r <= rxs_n_r + {15'h0000, rxs_pop_in};
         txs_n_r <= txs_n_r + {15'h0000, txs_pop_in};
      end
   end
endmodule : hpr_far_model
`default_nettype wire

// >>> tb/hpr_read_port_tb_top.sv
// self-checking bench of the host read port
// assumes hpr_far_model supplies rx words, status heads and registers
`timescale 1ns/1ps
`default_nettype none
module hpr_read_port_tb_top;
   logic clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic cs_n = 1'b1;
   logic rd_n = 1'b1;
   logic fs = 1'b0;
   logic en = 1'b0;
   logic [6:0] addr = 7'h00;
   logic [15:0] data, rxw, rxsw, txsw, csrd;
   logic [6:0] csra;
   logic oe, rxv, rxr, rxsp, txsp, snap, und, over;
   logic [1:0] lane;
   // register words picked for the read-gap scenarios, values arbitrary
   localparam logic [6:0] TEST_WORD = 7'h11;
   localparam logic [6:0] RX_INFO_WORD = 7'h0C;
   localparam logic [6:0] TX_INFO_WORD = 7'h0D;
   localparam logic [6:0] DROP_WORD = 7'h18;
   localparam logic [6:0] PATH_CTRL_WORD = 7'h15;
   int miscompares = 0;
   int total_checks = 0;
   int rxs_n = 0;
   int txs_n = 0;
   int rxi = 0;
   int snap_n = 0;
   always #2.5 clk_in = ~clk_in;
   always @(posedge clk_in) begin
      rxs_n <= rxs_n + int'(rxsp === 1'b1);
      txs_n <= txs_n + int'(txsp === 1'b1);
      snap_n <= snap_n + int'(snap === 1'b1);
   end
   hpr_read_port hpr_read_port_inst (.clk_in(clk_in), .rst_in(rst_in),
      .chip_select_n_in(cs_n), .read_strobe_n_in(rd_n), .fifo_sel_in(fs),
      .addr_in(addr), .data_out(data), .data_oe_out(oe), .rx_word_in(rxw),
      .rx_valid_in(rxv), .rx_ready_out(rxr), .rxs_word_in(rxsw),
      .txs_word_in(txsw), .rxs_pop_out(rxsp), .txs_pop_out(txsp),
      .csr_addr_out(csra), .csr_rdata_in(csrd), .csr_snap_out(snap),
      .lane_out(lane), .rx_underrun_out(und), .burst_over_out(over));
   hpr_far_model hpr_far_model_inst (.clk_in(clk_in), .rst_in(rst_in),
      .src_en_in(en), .rx_ready_in(rxr), .rx_word_out(rxw),
      .rx_valid_out(rxv), .rxs_pop_in(rxsp), .txs_pop_in(txsp),
      .csr_addr_in(csra), .rxs_word_out(rxsw), .txs_word_out(txsw),
      .csr_rdata_out(csrd));
   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : cyc
   // one read, 35 cycles long; one strobe rises first, the other later
   task automatic rd(input logic [6:0] a, input logic f, input logic cs_last,
                     input logic [15:0] exp);
      int s0;
      s0 = snap_n;
      addr = a;
      fs = f;
      cyc(1);
      cs_n = 1'b0;
      rd_n = 1'b0;
      cyc(8);
      chk(data, exp);
      chk({15'h0000, oe}, 16'h0001);
      chk({14'h0000, lane}, {14'h0000, a[1:0]});
      cyc(12);
      if (cs_last) rd_n = 1'b1;
      else cs_n = 1'b1;
      cyc(5);
      chk({15'h0000, oe}, 16'h0000);
      cs_n = 1'b1;
      rd_n = 1'b1;
      cyc(9);
      chk(16'(snap_n - s0), 16'h0001);
   endtask : rd
   // strobes held low, address stepped every 34 cycles
   task automatic burst(input logic f, input int n);
      fs = f;
      addr = 7'h40;
      cyc(1);
      cs_n = 1'b0;
      rd_n = 1'b0;
      for (int i = 0; i < n; i++) begin
         addr = 7'h40 + 7'(i);
         cyc(10);
         chk(data, f ? 16'hC000 + 16'(rxi) : {addr, 9'h055});
         chk({15'h0000, over}, {15'h0000, !f && i == 16});
         rxi += int'(f);
         cyc(24);
      end
      cs_n = 1'b1;
      rd_n = 1'b1;
      cyc(10);
      chk({15'h0000, over}, 16'h0000);
   endtask : burst
   initial begin
      cyc(12);
      rst_in = 1'b0;
      cyc(4);
      en = 1'b1;
      cyc(8);
      chk({15'h0000, rxr}, 16'h0000);
      rd(7'h13, 1'b0, 1'b0, {7'h13, 9'h055});
      rd(7'h7D, 1'b1, 1'b1, 16'hC000);
      rd(7'h02, 1'b0, 1'b0, 16'hC001);
      // one dummy read spaces rx data from the rx info register
      rd(TEST_WORD, 1'b0, 1'b0, {TEST_WORD, 9'h055});
      rd(RX_INFO_WORD, 1'b0, 1'b1, {RX_INFO_WORD, 9'h055});
      // path control read with the skip bit clear, then two dummies
      rd(PATH_CTRL_WORD, 1'b0, 1'b0, {PATH_CTRL_WORD, 9'h055});
      rd(TEST_WORD, 1'b0, 1'b1, {TEST_WORD, 9'h055});
      rd(TEST_WORD, 1'b0, 1'b0, {TEST_WORD, 9'h055});
      rd(hpr_pkg::RXS_WORD, 1'b0, 1'b1, 16'h5000);
      chk(16'(rxs_n), 16'h0001);
      rd(hpr_pkg::TXS_WORD, 1'b0, 1'b0, 16'h6000);
      chk(16'(txs_n), 16'h0001);
      rd(TEST_WORD, 1'b0, 1'b1, {TEST_WORD, 9'h055});
      rd(TX_INFO_WORD, 1'b0, 1'b0, {TX_INFO_WORD, 9'h055});
      // two dummies between the two dropped-count reads
      rd(DROP_WORD, 1'b0, 1'b1, {DROP_WORD, 9'h055});
      rd(TEST_WORD, 1'b0, 1'b0, {TEST_WORD, 9'h055});
      rd(TEST_WORD, 1'b0, 1'b1, {TEST_WORD, 9'h055});
      rd(DROP_WORD, 1'b0, 1'b0, {DROP_WORD, 9'h055});
      en = 1'b0;
      rd(7'h79, 1'b1, 1'b0, 16'hC002);
      rd(7'h4B, 1'b1, 1'b1, 16'hC003);
      rd(7'h58, 1'b1, 1'b0, 16'h0000);
      chk({15'h0000, und}, 16'h0001);
      en = 1'b1;
      rxi = 4;
      burst(1'b0, 17);
      burst(1'b1, 18);
      report_and_stop();
   end
   initial begin
      repeat (20000) @(posedge clk_in);
      miscompares++;
      report_and_stop();
   end
endmodule : hpr_read_port_tb_top
`default_nettype wire
